// *** hw/tpcl_pkg.sv ***
// Constants, types and register map of the tape parity check logic
package tpcl_pkg;
  localparam logic [7:0] TPCL_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TPCL_ADDR_STATUS = 8'h04;
  localparam logic [7:0] TPCL_ADDR_MASK = 8'h08;
  localparam logic [7:0] TPCL_ADDR_SENSE = 8'h0C;
  localparam logic [7:0] TPCL_ADDR_LPAR = 8'h10;
  localparam logic [7:0] TPCL_ADDR_CHAR = 8'h14;
  localparam int TPCL_CTRL_MODE_LSB = 0;
  localparam int TPCL_CTRL_WRITE_BIT = 3;
  localparam int TPCL_CTRL_TMARK_BIT = 4;
  localparam int TPCL_CTRL_DUAL_BIT = 5;
  localparam int TPCL_CTRL_CONV_BIT = 6;
  localparam int TPCL_ST_VERT_BIT = 0;
  localparam int TPCL_ST_LONG_BIT = 1;
  localparam int TPCL_ST_CLIP_BIT = 4;
  localparam int TPCL_S6_SEVEN_BIT = 0;
  localparam int TPCL_S6_DUAL_BIT = 2;
  localparam int TPCL_S6_DENS_BIT = 3;
  localparam int TPCL_S6_NINE_BIT = 4;
  localparam logic [31:0] TPCL_CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] TPCL_MASK_RESET = 8'h00;
  localparam logic [31:0] TPCL_UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    TPCL_MODE_NRZI9 = 3'b000,
    TPCL_MODE_NRZI7 = 3'b001,
    TPCL_MODE_PE = 3'b010,
    TPCL_MODE_GCR = 3'b011
  } tpcl_mode_e;

  typedef enum logic [1:0] {
    TPCL_ST_IDLE = 2'b00,
    TPCL_ST_DATA = 2'b01,
    TPCL_ST_CHECK = 2'b10
  } tpcl_state_e;

  typedef struct packed {
    logic byteValid;
    logic [8:0] bits;
  } tpcl_byte_s;

  typedef struct packed {
    logic parityFail;
    logic corrected;
    logic ptrValid;
    logic twoPtrSet;
    logic eccFound;
    logic ptrMismatch;
    logic singleTrack;
    logic lostByte;
  } tpcl_err_s;
endpackage

// *** hw/tpcl_parity_reg.sv ***
// Per-track longitudinal parity register
`timescale 1ns/1ps
`default_nettype none
module tpcl_parity_reg #(
  parameter int TRACKS = 9
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic accumulate,
  input wire logic [TRACKS-1:0] bits,
  output logic [TRACKS-1:0] parity
);
  initial begin
    if (TRACKS < 1 || TRACKS > 9) begin
      $error("TRACKS out of range");
    end
  end

  logic [TRACKS-1:0] parity_next;

  genvar t;
  generate
    for (t = 0; t < TRACKS; t++) begin : gTrack
      // Clear wins so a block never inherits the previous count
      assign parity_next[t] = clear ? 1'b0 : (accumulate ? (parity[t] ^ bits[t]) : parity[t]);
    end
  endgenerate

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      parity <= '0;
    end else begin
      parity <= parity_next;
    end
  end
endmodule
`default_nettype wire

// *** hw/tpcl_top.sv ***
// Tape redundancy check logic with APB register access
`timescale 1ns/1ps
`default_nettype none
// Operation
// - A block with an odd one count in any track sets the longitudinal check error in NRZI 7 or 9 track work.
// - A per-track longitudinal parity register follows every track over a block, used only in NRZI modes.
// - An even track leaves its write trigger untouched at check-byte time, writing no bit there.
// - An odd track has its write trigger on at check-byte time and it is reset, writing a one bit.
// - A 6250 read with no two pointers set and no located track sets the vertical check flag.
// - A 6250 write single-track error whose pointer and code disagree sets the vertical check flag.
// - A phase-encoded byte parity failure without a track pointer sets the vertical check flag.
// - An uncorrectable byte parity failure in an NRZI read sets the vertical check flag.
// - Every byte across the tape width has its parity checked in NRZI and phase-encoded modes; 6250 (GCR) work does not use it.
// - A wrong-parity byte in an NRZI write or tape-mark write sets the high-clip parity flag.
// - The same flag also reports a lost byte in 7-track reading or writing.
// - Sense byte 6 bit 2 shows dual density in 6250 and phase-encoded-only 1600 modes.
// - Sense byte 6 bit 3 is off at 1600 bpi and on at any other density.
// - The loop-write command at load point selects phase-encoded mode.
// - An NRZI one bit is written by toggling the track write trigger once.
// - With the converter off, the 7-track character gate toggles once per written byte plus once for the check character of odd records.
module tpcl_top #(
  parameter int TRACKS = 9
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic blockStart,
  input wire logic blockEnd,
  input wire tpcl_pkg::tpcl_byte_s tape_unit_read_bus,
  input wire tpcl_pkg::tpcl_err_s errIn,
  input wire logic diagnostic_loop_write_command,
  input wire logic atLoadPoint,
  output logic [TRACKS-1:0] tape_unit_write_bus,
  output logic charGate,
  output logic [7:0] senseByte3,
  output logic [7:0] senseByte6,
  output logic irq
);
  initial begin
    if (TRACKS != 9) begin
      $error("TRACKS must be 9");
    end
  end

  tpcl_pkg::tpcl_state_e state_reg, state_next;
  logic [31:0] ctrl_reg;
  logic [7:0] status_reg, mask_reg;
  logic peLatch_reg;
  logic oddRecord_reg;
  logic [TRACKS-1:0] trig_reg;
  logic [7:0] byteCount_reg;
  logic [TRACKS-1:0] lpar;

  wire logic setup = psel && !penable;
  wire logic access = psel && penable;
  // Writes land only on the edge that completes the transfer
  wire logic wrEn = access && pwrite && pready;
  wire logic selCtrl = paddr == tpcl_pkg::TPCL_ADDR_CTRL;
  wire logic selStatus = paddr == tpcl_pkg::TPCL_ADDR_STATUS;
  wire logic selMask = paddr == tpcl_pkg::TPCL_ADDR_MASK;
  wire logic selSense = paddr == tpcl_pkg::TPCL_ADDR_SENSE;
  wire logic selLpar = paddr == tpcl_pkg::TPCL_ADDR_LPAR;
  wire logic selChar = paddr == tpcl_pkg::TPCL_ADDR_CHAR;
  wire logic mapped = selCtrl || selStatus || selMask || selSense || selLpar || selChar;

  wire tpcl_pkg::tpcl_mode_e modeSw = tpcl_pkg::tpcl_mode_e'(ctrl_reg[tpcl_pkg::TPCL_CTRL_MODE_LSB +: 3]);
  // Loop write at load point forces phase encoding until software rewrites the mode
  wire tpcl_pkg::tpcl_mode_e mode = peLatch_reg ? tpcl_pkg::TPCL_MODE_PE : modeSw;
  wire logic isWrite = ctrl_reg[tpcl_pkg::TPCL_CTRL_WRITE_BIT];
  wire logic isTmark = ctrl_reg[tpcl_pkg::TPCL_CTRL_TMARK_BIT];
  wire logic dualDen = ctrl_reg[tpcl_pkg::TPCL_CTRL_DUAL_BIT];
  wire logic convOn = ctrl_reg[tpcl_pkg::TPCL_CTRL_CONV_BIT];
  wire logic modeNrzi = mode == tpcl_pkg::TPCL_MODE_NRZI9 || mode == tpcl_pkg::TPCL_MODE_NRZI7;
  wire logic mode7 = mode == tpcl_pkg::TPCL_MODE_NRZI7;
  wire logic modeGcr = mode == tpcl_pkg::TPCL_MODE_GCR;
  wire logic modePe = mode == tpcl_pkg::TPCL_MODE_PE;

  // 7-track bytes have only tracks 0 to 6; the top two bits are ignored there
  wire logic [TRACKS-1:0] trackMask = mode7 ? 9'h07F | 9'h000 : 9'h1FF;
  wire logic [TRACKS-1:0] dataBits = tape_unit_read_bus.bits & trackMask;
  wire logic inData = state_reg == tpcl_pkg::TPCL_ST_DATA;
  wire logic takeByte = inData && tape_unit_read_bus.byteValid;
  wire logic [TRACKS-1:0] noParity = 9'h000;

  // Odd parity per byte across the tape; 7-track uses seven tracks
  wire logic badParity = ~(^dataBits);
  wire logic byteBad = takeByte && (badParity || errIn.parityFail);

  wire logic vertGcrRd = modeGcr && !isWrite && takeByte && !errIn.twoPtrSet && !errIn.eccFound;
  wire logic vertGcrWr = modeGcr && isWrite && takeByte && errIn.singleTrack && errIn.ptrMismatch;
  wire logic vertPe = modePe && byteBad && !errIn.ptrValid;
  wire logic vertNrzi = modeNrzi && !isWrite && byteBad && !errIn.corrected;
  wire logic evVert = vertGcrRd || vertGcrWr || vertPe || vertNrzi;
  // Longitudinal parity should be even at block end
  wire logic evLong = modeNrzi && blockEnd && inData && (|(lpar & trackMask));
  wire logic evClip = (modeNrzi && (isWrite || isTmark) && byteBad)
    || (mode7 && takeByte && errIn.lostByte);

  wire logic [7:0] evVec = {3'h0, evClip, 2'h0, evLong, evVert};
  wire logic [7:0] clrVec = (wrEn && selStatus) ? pwdata[7:0] : 8'h00;
  // Set beats clear so an event in the clearing cycle survives
  wire logic [7:0] status_next = (status_reg & ~clrVec) | evVec;
  wire logic irq_next = |(status_next & mask_reg);

  // Density bits of sense byte 6
  wire logic dualShown = (modeGcr || modePe) && dualDen;
  wire logic densOn = !modePe;
  wire logic [7:0] sense6_next = {3'h0, mode == tpcl_pkg::TPCL_MODE_NRZI9 || modeGcr, densOn, dualShown,
    1'b0, mode7};
  wire logic [7:0] sense3_next = status_next;

  wire logic [31:0] readMux = selCtrl ? ctrl_reg
    : selStatus ? {24'h000000, status_reg}
    : selMask ? {24'h000000, mask_reg}
    : selSense ? {16'h0000, senseByte6, senseByte3}
    : selLpar ? {23'h000000, lpar}
    : selChar ? {24'h000000, byteCount_reg}
    : tpcl_pkg::TPCL_UNMAPPED_DATA;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tpcl_pkg::TPCL_ST_IDLE: begin
        if (blockStart) begin
          state_next = tpcl_pkg::TPCL_ST_DATA;
        end
      end
      tpcl_pkg::TPCL_ST_DATA: begin
        if (blockEnd) begin
          state_next = (modeNrzi && isWrite) ? tpcl_pkg::TPCL_ST_CHECK : tpcl_pkg::TPCL_ST_IDLE;
        end
      end
      tpcl_pkg::TPCL_ST_CHECK: begin
        state_next = tpcl_pkg::TPCL_ST_IDLE;
      end
      default: begin
        state_next = tpcl_pkg::TPCL_ST_IDLE;
      end
    endcase
  end

  // Write triggers toggle once per one bit; at check time the odd tracks, whose triggers are on, are reset
  wire logic inCheck = state_reg == tpcl_pkg::TPCL_ST_CHECK;
  wire logic [TRACKS-1:0] trigToggle = (takeByte && modeNrzi && isWrite) ? dataBits : noParity;
  wire logic [TRACKS-1:0] trigCheck = trig_reg & ~(lpar & trackMask);
  wire logic [TRACKS-1:0] trig_next = blockStart ? noParity
    : inCheck ? trigCheck
    : trig_reg ^ trigToggle;
  // With the converter off the gate toggles per written data byte; odd 7-track records gain one for the check character
  wire logic gateByte = takeByte && mode7 && isWrite && !convOn;
  wire logic gateCheck = inCheck && mode7 && !convOn && oddRecord_reg;
  wire logic charGate_next = charGate ^ (gateByte || gateCheck);
  wire logic oddRecord_next = blockStart ? 1'b0 : (oddRecord_reg ^ takeByte);
  wire logic [7:0] byteCount_next = blockStart ? 8'h00 : byteCount_reg + {7'h00, takeByte};
  wire logic peLatch_next = (diagnostic_loop_write_command && atLoadPoint) ? 1'b1
    : (wrEn && selCtrl) ? 1'b0 : peLatch_reg;

  tpcl_parity_reg #(
    .TRACKS(TRACKS)
  ) uParity (
    .clock(clock),
    .sys_rst(sys_rst),
    .clear(blockStart),
    .accumulate(takeByte && modeNrzi),
    .bits(dataBits),
    .parity(lpar)
  );

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= tpcl_pkg::TPCL_ST_IDLE;
      trig_reg <= '0;
      charGate <= 1'b0;
      oddRecord_reg <= 1'b0;
      byteCount_reg <= 8'h00;
      peLatch_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      trig_reg <= trig_next;
      charGate <= charGate_next;
      oddRecord_reg <= oddRecord_next;
      byteCount_reg <= byteCount_next;
      peLatch_reg <= peLatch_next;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= tpcl_pkg::TPCL_CTRL_RESET;
      mask_reg <= tpcl_pkg::TPCL_MASK_RESET;
      status_reg <= 8'h00;
      irq <= 1'b0;
      senseByte3 <= 8'h00;
      senseByte6 <= 8'h00;
      tape_unit_write_bus <= '0;
    end else begin
      if (wrEn && selCtrl) begin
        ctrl_reg <= pwdata;
      end
      if (wrEn && selMask) begin
        mask_reg <= pwdata[7:0];
      end
      status_reg <= status_next;
      irq <= irq_next;
      senseByte3 <= sense3_next;
      senseByte6 <= sense6_next;
      tape_unit_write_bus <= trig_next;
    end
  end

  // No wait state: ready rises in the first access cycle and data is registered with it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? readMux : 32'h0000_0000;
      pslverr <= setup && !mapped;
    end
  end

  wire logic unusedBits = ^ctrl_reg[31:7];
endmodule
`default_nettype wire

// *** tb/tpcl_top_assertions.sv ***
// Port assertions for the tape parity check logic
`timescale 1ns/1ps
`default_nettype none
module tpcl_checker #(parameter int TRACKS = 9) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic blockStart,
  input wire logic diagnostic_loop_write_command,
  input wire logic atLoadPoint,
  input wire logic [TRACKS-1:0] tape_unit_write_bus,
  input wire logic [7:0] senseByte3,
  input wire logic [7:0] senseByte6,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [7:0] clr;
  // Flags may only fall after a completed status write of ones
  assign clr = (psel && penable && pready && pwrite && paddr == tpcl_pkg::TPCL_ADDR_STATUS) ? pwdata[7:0] : 8'h00;
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no pready after setup");
  property p_slvErr; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_slvErr: assert property (p_slvErr) else $error("error response not clean");
  property p_irq; (senseByte3 == 8'h00) [*2] |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq without status");
  property p_longFlag; $fell(senseByte3[1]) |-> $past(clr[1]) || $past(clr[1], 2); endproperty
  a_longFlag: assert property (p_longFlag) else $error("longitudinal flag lost");
  property p_vertFlag; $fell(senseByte3[0]) |-> $past(clr[0]) || $past(clr[0], 2); endproperty
  a_vertFlag: assert property (p_vertFlag) else $error("vertical flag lost");
  property p_clipFlag; $fell(senseByte3[4]) |-> $past(clr[4]) || $past(clr[4], 2); endproperty
  a_clipFlag: assert property (p_clipFlag) else $error("clip flag lost");
  property p_loopPe; diagnostic_loop_write_command && atLoadPoint |-> ##[1:3] !senseByte6[3]; endproperty
  a_loopPe: assert property (p_loopPe) else $error("loop write kept density bit");
  property p_blockClr; blockStart |-> ##[1:2] tape_unit_write_bus == '0; endproperty
  a_blockClr: assert property (p_blockClr) else $error("triggers not cleared");
  c_block: cover property (blockStart);
  c_irq: cover property ($rose(irq));
  c_slvErr: cover property (pslverr);
endmodule
bind tpcl_top tpcl_checker #(.TRACKS(TRACKS)) i_tpcl_checker (.clock, .sys_rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pslverr, .blockStart, .diagnostic_loop_write_command, .atLoadPoint,
  .tape_unit_write_bus, .senseByte3, .senseByte6, .irq);
`default_nettype wire

// *** tb/tpcl_tape_model.sv ***
// Tape unit model driving the read bus
`timescale 1ns/1ps
`default_nettype none
module tpcl_tape_model (
  input wire logic clock,
  input wire logic go,
  input wire logic [8:0] bitsIn,
  input wire logic [7:0] errReq,
  output var tpcl_pkg::tpcl_byte_s rdBus,
  output var tpcl_pkg::tpcl_err_s errOut
);
  initial rdBus = '0;
  initial errOut = '0;
  // Idle lines flip so a stale byte never looks valid
  always @(posedge clock) begin
    rdBus.byteValid <= go;
    rdBus.bits <= go ? bitsIn : ~rdBus.bits;
    errOut <= go ? errReq : ~errOut;
  end
endmodule
`default_nettype wire

// *** tb/tpcl_top_bench.sv ***
// Self-checking bench for the tape parity check logic
`timescale 1ns/1ps
`default_nettype none
module tpcl_top_bench;
  logic clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic blockStart = 1'b0, blockEnd = 1'b0, diagnostic_loop_write_command = 1'b0, atLoadPoint = 1'b0;
  logic pready, pslverr, charGate, irq, err, cgLast = 1'b0;
  logic [7:0] paddr = 8'h00, errReq = 8'h00, senseByte3, senseByte6;
  logic [8:0] bitsIn = 9'h000, tape_unit_write_bus, lpar;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, seed = 32'hE99B4426;
  tpcl_pkg::tpcl_byte_s tape_unit_read_bus;
  tpcl_pkg::tpcl_err_s errIn;
  int n_errors = 0, check_count = 0, cgCount = 0;
  logic [7:0] vc [6] = '{8'h00, 8'h00, 8'h02, 8'h03, 8'h03, 8'h0B};
  logic [7:0] ve [6] = '{8'h80, 8'hC0, 8'h80, 8'h80, 8'h88, 8'h86};
  logic vx [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  tpcl_top i_tpcl_top (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .blockStart, .blockEnd, .tape_unit_read_bus, .errIn, .diagnostic_loop_write_command,
    .atLoadPoint, .tape_unit_write_bus, .charGate, .senseByte3, .senseByte6, .irq);
  tpcl_tape_model i_tpcl_tape_model (.clock, .go, .bitsIn, .errReq, .rdBus(tape_unit_read_bus), .errOut(errIn));
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cgLast <= charGate;
    if (charGate !== cgLast) cgCount <= cgCount + 1;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Odd byte parity on the ninth track
  function automatic logic [8:0] par9(input logic [31:0] v);
    return {~^v[7:0], v[7:0]};
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      finish_test();
    end
  endtask
  task automatic tbyte(input logic [8:0] b, input logic [7:0] e);
    @(posedge clock);
    go <= 1'b1;
    bitsIn <= b;
    errReq <= e;
    @(posedge clock);
    go <= 1'b0;
  endtask
  // Dup sends each byte twice, leaving every track even
  task automatic blk(input int n, input logic bad, input logic [7:0] e, input logic dup);
    logic [8:0] d;
    @(posedge clock);
    blockStart <= 1'b1;
    @(posedge clock);
    blockStart <= 1'b0;
    lpar = 9'h000;
    for (int i = 0; i < n; i++) begin
      d = par9(rnd()) ^ {bad && i == 0, 8'h00};
      lpar = lpar ^ d;
      tbyte(d, e);
      if (dup) begin
        lpar = lpar ^ d;
        tbyte(d, e);
      end
    end
    repeat (3) @(posedge clock);
  endtask
  task automatic endb();
    @(posedge clock);
    blockEnd <= 1'b1;
    @(posedge clock);
    blockEnd <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  initial begin
    int g;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    apb(1'b0, tpcl_pkg::TPCL_ADDR_CTRL, 32'h0);
    chk("ctrl reset", tpcl_pkg::TPCL_CTRL_RESET, rd);
    apb(1'b0, tpcl_pkg::TPCL_ADDR_MASK, 32'h0);
    chk("mask reset", tpcl_pkg::TPCL_MASK_RESET, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {tpcl_pkg::TPCL_UNMAPPED_DATA[30:0], 1'b1}, {rd[30:0], err});
    apb(1'b1, tpcl_pkg::TPCL_ADDR_CTRL, 32'h8);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, tpcl_pkg::TPCL_ADDR_STATUS, 32'hFF);
      blk(6, 1'b0, 8'h00, k[0]);
      chk("triggers", lpar, tape_unit_write_bus);
      apb(1'b0, tpcl_pkg::TPCL_ADDR_LPAR, 32'h0);
      chk("lpar", lpar, rd);
      endb();
      chk("check byte", 32'h0, tape_unit_write_bus);
      apb(1'b0, tpcl_pkg::TPCL_ADDR_STATUS, 32'h0);
      chk("lrc", {30'h00000000, lpar != 9'h000, 1'b0}, rd & 32'h13);
    end
    blk(3, 1'b1, 8'h00, 1'b0);
    endb();
    apb(1'b0, tpcl_pkg::TPCL_ADDR_STATUS, 32'h0);
    chk("clip", 32'h10, rd & 32'h10);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, m == 1 ? tpcl_pkg::TPCL_ADDR_STATUS : tpcl_pkg::TPCL_ADDR_MASK, m == 2 ? 32'h0 : 32'h10);
      repeat (3) @(posedge clock);
      chk("irq", m == 0, irq);
    end
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, tpcl_pkg::TPCL_ADDR_CTRL, vc[k]);
      apb(1'b1, tpcl_pkg::TPCL_ADDR_STATUS, 32'hFF);
      blk(1, 1'b1, ve[k], 1'b0);
      endb();
      apb(1'b0, tpcl_pkg::TPCL_ADDR_STATUS, 32'h0);
      chk("vertical", {vc[k][2:1] == 2'b00 && lpar != 9'h000, vx[k]}, rd & 32'h3);
    end
    // Converter on must keep the gate still
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, tpcl_pkg::TPCL_ADDR_CTRL, c ? 32'h49 : 32'h9);
      g = cgCount;
      blk(3, 1'b0, 8'h00, 1'b0);
      endb();
      chk("gate toggles", c ? 32'h0 : 32'h4, cgCount - g);
    end
    apb(1'b1, tpcl_pkg::TPCL_ADDR_CTRL, 32'h1);
    apb(1'b1, tpcl_pkg::TPCL_ADDR_STATUS, 32'hFF);
    blk(2, 1'b0, 8'h01, 1'b0);
    endb();
    apb(1'b0, tpcl_pkg::TPCL_ADDR_STATUS, 32'h0);
    chk("lost byte", 32'h10, rd & 32'h10);
    chk("sense byte 3", 32'h10, senseByte3 & 8'h10);
    apb(1'b0, tpcl_pkg::TPCL_ADDR_CHAR, 32'h0);
    chk("byte count", 32'h2, rd);
    apb(1'b1, tpcl_pkg::TPCL_ADDR_CTRL, 32'h10);
    apb(1'b1, tpcl_pkg::TPCL_ADDR_STATUS, 32'hFF);
    blk(1, 1'b1, 8'hC0, 1'b0);
    endb();
    apb(1'b0, tpcl_pkg::TPCL_ADDR_STATUS, 32'h0);
    chk("tape mark clip", 32'h10, rd & 32'h11);
    apb(1'b1, tpcl_pkg::TPCL_ADDR_CTRL, 32'h22);
    repeat (3) @(posedge clock);
    chk("pe dual", 32'h4, senseByte6 & 8'h0C);
    apb(1'b1, tpcl_pkg::TPCL_ADDR_CTRL, 32'h3);
    repeat (3) @(posedge clock);
    chk("gcr single", 32'h8, senseByte6 & 8'h0C);
    apb(1'b1, tpcl_pkg::TPCL_ADDR_CTRL, 32'h0);
    for (int a = 0; a < 2; a++) begin
      @(posedge clock);
      diagnostic_loop_write_command <= 1'b1;
      atLoadPoint <= a[0];
      @(posedge clock);
      diagnostic_loop_write_command <= 1'b0;
      repeat (4) @(posedge clock);
      chk("loop write", a ? 32'h0 : 32'h8, senseByte6 & 8'h08);
    end
    finish_test();
  end
endmodule
`default_nettype wire
